// ==== dv/fsi_dev_model.sv ====
// Device model: captures serial words and reports lock
`timescale 1ns/100ps
`default_nettype none
module fsi_dev_model (
    input wire logic i_mclk,   // System clock
    input wire logic i_sclk,   // Serial clock
    input wire logic i_sdata,  // Serial data
    input wire logic i_strobe, // Word latch strobe
    output logic o_lock_detect // Lock indication
);
    localparam int PCMP = 4;
    logic [23:0] wd [0:63];
    int wl [0:63];
    int n = 0;
    int cnt = 0;
    int modv = 0;
    int rep_len = 0;
    logic [23:0] sh = 24'h000000;
    logic pd = 1'b1;
    logic varb = 1'b0;
    logic dith = 1'b0;
    event hop;
    initial o_lock_detect = 1'b0;
    always @(posedge i_sclk) begin
        sh = {sh[22:0], i_sdata};
        cnt++;
    end
    always @(posedge i_strobe) begin
        wd[n] = sh & ((24'h000001 << cnt) - 24'h000001);
        wl[n] = cnt;
        cnt = 0;
        case (wd[n][2:0])
            3'h5: begin
                pd = wd[n][5];
                // Power-down resets the lock detector
                if (pd) o_lock_detect <= 1'b0;
            end
            3'h1: modv = int'(wd[n][14:3]);
            3'h6: begin
                varb = (wd[n][15:12] == 4'h0);
                dith = (wd[n][15:12] == 4'h3);
            end
            3'h0: if (!pd) ->hop;
            default: ;
        endcase
        // Code repeat length of the modulator
        rep_len = dith ? (1 << 21) : (modv % 6 == 0) ? 6 * modv : (modv % 3 == 0) ? 3 * modv
            : (modv % 2 == 0) ? 2 * modv : modv;
        n++;
    end
    // Hop start, then settle one compare cycle, or 17 compare cycles when varb is set
    always @(hop) begin
        o_lock_detect <= 1'b0;
        repeat ((varb ? 16 : 0) + 1) repeat (PCMP) @(posedge i_mclk);
        o_lock_detect <= 1'b1;
    end
endmodule
`default_nettype wire

// ==== dv/fsi_host_chk.sv ====
// Checker: bus answer timing and serial framing of the host
`timescale 1ns/100ps
`default_nettype none
module fsi_host_chk #(
    parameter int WAIT_CYCLES = 100 // Discharge wait
) (
    input wire logic i_mclk,                // Clock
    input wire logic i_rst_n,               // Reset
    input wire logic [3:0] i_avs_address,   // Address
    input wire logic i_avs_read,            // Read
    input wire logic i_avs_write,           // Write
    input wire logic [31:0] i_avs_writedata, // Write data
    input wire logic [31:0] o_avs_readdata, // Read data
    input wire logic o_avs_waitrequest,     // Wait
    input wire logic i_lock_detect,         // Lock
    input wire logic o_sclk,                // Serial clock
    input wire logic o_sdata,               // Serial data
    input wire logic o_word_latch_strobe    // Strobe
);
    logic sclk_d;
    logic strb_d;
    logic [4:0] bits_r;
    logic [3:0] words_r;
    logic [31:0] idle_r;
    wire sclk_rise = o_sclk & ~sclk_d;
    wire strb_rise = o_word_latch_strobe & ~strb_d;
    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            sclk_d <= 1'b0;
            strb_d <= 1'b0;
            bits_r <= 5'h00;
            words_r <= 4'h0;
            idle_r <= 32'h00000000;
        end else begin
            sclk_d <= o_sclk;
            strb_d <= o_word_latch_strobe;
            bits_r <= o_word_latch_strobe ? 5'h00 : bits_r + {4'h0, sclk_rise};
            words_r <= (strb_rise && words_r != 4'hF) ? words_r + 4'h1 : words_r;
            idle_r <= strb_rise ? 32'h00000000 : idle_r + 32'h00000001;
        end
    end
    default clocking cb @(posedge i_mclk); endclocking
    default disable iff (!i_rst_n);
    sequence s_half(s);
        s[*8] ##2 s ##1 !s;
    endsequence
    sequence s_answer;
        o_avs_waitrequest ##1 !o_avs_waitrequest;
    endsequence
    AST_BUS_ANSWER: assert property ($rose(i_avs_read || i_avs_write) |-> s_answer)
        else $error("bus answer not one cycle after request");
    AST_BUS_IDLE: assert property (!(i_avs_read || i_avs_write) |-> !o_avs_waitrequest)
        else $error("wait request without request");
    AST_SCLK_HALF: assert property ($rose(o_sclk) |-> s_half(o_sclk))
        else $error("serial clock high phase wrong");
    AST_STROBE_HALF: assert property ($rose(o_word_latch_strobe) |-> s_half(o_word_latch_strobe))
        else $error("strobe width wrong");
    AST_QUIET_STROBE: assert property (o_word_latch_strobe |-> !o_sclk)
        else $error("serial clock during strobe");
    AST_DATA_STEADY: assert property (o_sclk && sclk_d |-> $stable(o_sdata))
        else $error("data moved while clock high");
    AST_WORD_BITS: assert property (strb_rise |-> bits_r inside {5'h08, 5'h10, 5'h18})
        else $error("strobe after partial word");
    AST_FIRST_WORD: assert property (strb_rise && words_r == 4'h0 |-> bits_r == 5'h08)
        else $error("first word not eight bits");
    AST_DISCHARGE: assert property (sclk_rise && words_r == 4'h2 |-> idle_r >= 32'(WAIT_CYCLES))
        else $error("third word too soon");
endmodule
bind fsi_host fsi_host_chk #(.WAIT_CYCLES(WAIT_CYCLES)) i_chk (
    .i_mclk(i_mclk), .i_rst_n(i_rst_n), .i_avs_address(i_avs_address),
    .i_avs_read(i_avs_read), .i_avs_write(i_avs_write), .i_avs_writedata(i_avs_writedata),
    .o_avs_readdata(o_avs_readdata), .o_avs_waitrequest(o_avs_waitrequest),
    .i_lock_detect(i_lock_detect), .o_sclk(o_sclk), .o_sdata(o_sdata),
    .o_word_latch_strobe(o_word_latch_strobe));
`default_nettype wire

// ==== dv/fsi_host_tb_top.sv ====
// Testbench: drives the host over the bus, judges words seen by the device model
`timescale 1ns/100ps
`default_nettype none
module fsi_host_tb_top import fsi_pkg::*; ;
    localparam int LIMIT = 60000;
    logic i_mclk = 1'b0;
    logic rst_n = 1'b0;
    logic [3:0] adr = 4'h0;
    logic rd = 1'b0;
    logic wr = 1'b0;
    logic [31:0] wdat = 32'h00000000;
    logic [31:0] rdat;
    logic wreq, lock, sclk, sdata, strb;
    int mismatches = 0;
    int tests_run = 0;
    int cyc = 0;
    logic [23:0] ew [0:31];
    int el [0:31];
    int en;
    always #4 i_mclk = ~i_mclk;
    fsi_host #(.WAIT_CYCLES(100)) i_dut (
        .i_mclk(i_mclk), .i_rst_n(rst_n), .i_avs_address(adr), .i_avs_read(rd),
        .i_avs_write(wr), .i_avs_writedata(wdat), .o_avs_readdata(rdat),
        .o_avs_waitrequest(wreq), .i_lock_detect(lock), .o_sclk(sclk),
        .o_sdata(sdata), .o_word_latch_strobe(strb));
    fsi_dev_model i_dev (
        .i_mclk(i_mclk), .i_sclk(sclk), .i_sdata(sdata), .i_strobe(strb), .o_lock_detect(lock));
    task automatic report_and_stop();
        $display("mismatches=%0d tests_run=%0d", mismatches, tests_run);
        if (mismatches == 0 && tests_run > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    always @(posedge i_mclk) begin
        cyc++;
        if (cyc == LIMIT) begin
            mismatches++;
            report_and_stop();
        end
    end
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        tests_run++;
        if (g !== e) begin
            mismatches++;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d, output logic [31:0] q);
        logic ok;
        ok = 1'b0;
        rd <= !w;
        wr <= w;
        adr <= a;
        wdat <= d;
        // Values read here are those standing before the edge
        while (!ok) begin
            @(posedge i_mclk);
            ok = (wreq === 1'b0);
            q = rdat;
        end
        rd <= 1'b0;
        wr <= 1'b0;
        @(posedge i_mclk);
    endtask
    task automatic add(input logic [23:0] w, input int l);
        ew[en] = w;
        el[en] = l;
        en++;
    endtask
    task automatic t_regs();
        logic [31:0] q;
        bus(1'b0, REG_CTRL, 32'h0, q);
        chk("ctrl_reset", 32'h00410000, q & 32'h0FFF000F);
        bus(1'b0, REG_FREQ, 32'h0, q);
        chk("freq_reset", 32'h00480140, q & 32'h00FFFFFF);
        bus(1'b0, 4'h2, 32'h0, q);
        chk("unmapped", 32'h00000000, q);
        bus(1'b1, REG_MODE, 32'h0000000E, q);
        bus(1'b0, REG_MODE, 32'h0, q);
        chk("mode", 32'h0000000E, q & 32'h0000FFFF);
    endtask
    task automatic t_refuse(input logic [31:0] c);
        logic [31:0] q;
        int n0;
        n0 = i_dev.n;
        bus(1'b1, REG_CTRL, c, q);
        repeat (400) @(posedge i_mclk);
        bus(1'b0, REG_STATUS, 32'h0, q);
        chk("mod_err", 32'h1, 32'(q[4]));
        chk("words", 32'(n0), 32'(i_dev.n));
    endtask
    task automatic t_seq(input logic [31:0] c, input int rep);
        logic [31:0] q;
        int n0;
        n0 = i_dev.n;
        en = 0;
        add(24'h0000FD, 8);
        add(24'h00005B, 16);
        add(24'h000007, 16);
        add(24'h00000E, 16);
        add(c[1] ? 24'h00000E : 24'h00900E, 16);
        add(24'h004464, 24);
        add(24'h00446C, 24);
        add(24'h004394, 24);
        add(24'h0000D2, 16);
        add((24'h520209 & ~24'h007FF8) | {9'h000, c[27:16], 3'h0}, 24);
        add(24'h480140, 24);
        add(24'h00007B, 16);
        add(24'h000005, 8);
        add(24'h480140, 24);
        if (c[2]) add(24'h00300E, 16);
        bus(1'b1, REG_CTRL, c, q);
        bus(1'b1, REG_CTRL, c, q);
        while (i_dev.n - n0 < en) @(posedge i_mclk);
        repeat (600) @(posedge i_mclk);
        chk("count", 32'(en), 32'(i_dev.n - n0));
        chk("repeat", 32'(rep), 32'(i_dev.rep_len));
        for (int i = 0; i < en; i++) begin
            chk("word", 32'(ew[i]), 32'(i_dev.wd[n0 + i]));
            chk("bits", 32'(el[i]), 32'(i_dev.wl[n0 + i]));
        end
        q = 32'h0;
        for (int k = 0; k < 50 && q[5] !== 1'b1; k++) bus(1'b0, REG_STATUS, 32'h0, q);
        chk("mod_err_clr", 32'h0, 32'(q[4]));
        chk("lock", 32'h1, 32'(q[5]));
    endtask
    task automatic t_hop();
        logic [31:0] q;
        int n0;
        n0 = i_dev.n;
        bus(1'b1, REG_FREQ, 32'h00123450, q);
        bus(1'b1, REG_CTRL, 32'h00410008, q);
        while (i_dev.n == n0) @(posedge i_mclk);
        repeat (600) @(posedge i_mclk);
        chk("hop_count", 32'(n0 + 1), 32'(i_dev.n));
        chk("hop_word", 32'h00123450, 32'(i_dev.wd[n0]));
        chk("hop_bits", 32'd24, 32'(i_dev.wl[n0]));
        bus(1'b0, REG_STATUS, 32'h0, q);
        chk("hop_lock", 32'h1, 32'(q[5]));
    endtask
    initial begin
        repeat (2) @(posedge i_mclk);
        rst_n <= 1'b1;
        @(posedge i_mclk);
        t_regs();
        t_refuse(32'h000C0001);
        t_refuse(32'h00310005);
        t_seq(32'h00320005, 2097152);
        t_seq(32'h000D0003, 13);
        t_seq(32'h0FFF0001, 12285);
        t_hop();
        report_and_stop();
    end
endmodule
`default_nettype wire

// ==== rtl/fsi_divider.sv ====
// Enable pulse divider for the serial clock rate
`timescale 1ns/100ps
`default_nettype none
module fsi_divider
    import fsi_pkg::*;
#(
    parameter logic [7:0] HALF = SCLK_HALF
) (
    input wire logic i_mclk,  // System clock
    input wire logic i_rst_n, // Async reset
    input wire logic i_run,   // Divider enable
    output logic o_tick       // One-cycle enable
);
    logic [7:0] cnt_r;
    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            cnt_r <= 8'h00;
        end else if (!i_run || cnt_r == HALF - 8'h01) begin
            cnt_r <= 8'h00;
        end else begin
            cnt_r <= cnt_r + 8'h01;
        end
    end
    assign o_tick = i_run && (cnt_r == HALF - 8'h01);
endmodule
`default_nettype wire

// ==== rtl/fsi_host.sv ====
// Host controller: runs the synthesizer power-up sequence over the 3-wire link
// ----------------------------------------------------------------
// ----------------------------------------------------------------
`timescale 1ns/100ps
`default_nettype none
module fsi_host
    import fsi_pkg::*;
#(
    parameter int WAIT_CYCLES = WAIT_CYC // Discharge wait in clock cycles
) (
    input wire logic i_mclk,                // 125 MHz system clock
    input wire logic i_rst_n,               // Async reset, active low
    input wire logic [3:0] i_avs_address,   // Avalon byte address
    input wire logic i_avs_read,            // Avalon read
    input wire logic i_avs_write,           // Avalon write
    input wire logic [31:0] i_avs_writedata, // Avalon write data
    output logic [31:0] o_avs_readdata,     // Avalon read data
    output logic o_avs_waitrequest,         // Avalon wait request
    input wire logic i_lock_detect,         // Diagnostic output from device
    output logic o_sclk,                    // Serial clock to device
    output logic o_sdata,                   // Serial data to device
    output logic o_word_latch_strobe        // Word latch strobe to device
);
    // ----------------------------------------------------------------
    // Register file
    // ----------------------------------------------------------------
    logic ctrl_varb_r, ctrl_dither_r, start_r, hop_r, ack_r, mod_err_r;
    logic [11:0] mod_r;
    logic [WORD_W-1:0] freq_r;
    logic [15:0] mode_r;
    logic busy, done_r;
    logic ld_s1_r, ld_s2_r;
    fsi_step_t step_r;

    function automatic logic mod_ok(input logic [11:0] m, input logic dith);
        mod_ok = (m >= MOD_MIN) && (!dith || m >= MOD_MIN_DITHER);
    endfunction

    // Single-cycle waitrequest: each access is answered on the cycle after it is seen
    assign o_avs_waitrequest = (i_avs_read || i_avs_write) && !ack_r;

    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            ack_r <= 1'b0;
        end else begin
            ack_r <= (i_avs_read || i_avs_write) && !ack_r;
        end
    end

    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            ctrl_varb_r <= 1'b0;
            ctrl_dither_r <= 1'b0;
            mod_r <= MOD_RESET;
            freq_r <= W_FREQ_DEF;
            mode_r <= 16'h0000;
            start_r <= 1'b0;
            hop_r <= 1'b0;
            mod_err_r <= 1'b0;
        end else begin
            if (step_r == ST_PD_ALL && busy) begin
                start_r <= 1'b0;
            end
            // Hop request consumed once its frequency write is under way
            if (step_r == ST_FREQ2 && busy) begin
                hop_r <= 1'b0;
            end
            if (i_avs_write && ack_r) begin
                unique case (i_avs_address)
                    REG_CTRL: begin
                        if (i_avs_writedata[CTRL_START_BIT] && !busy) begin
                            if (mod_ok(i_avs_writedata[MOD_LSB +: 12], i_avs_writedata[CTRL_DITHER_BIT])) begin
                                start_r <= 1'b1;
                                mod_err_r <= 1'b0;
                            end else begin
                                mod_err_r <= 1'b1;
                            end
                        end
                        if (i_avs_writedata[CTRL_HOP_BIT] && !busy) begin
                            hop_r <= 1'b1;
                        end
                        ctrl_varb_r <= i_avs_writedata[CTRL_VARB_BIT];
                        ctrl_dither_r <= i_avs_writedata[CTRL_DITHER_BIT];
                        mod_r <= i_avs_writedata[MOD_LSB +: 12];
                    end
                    REG_FREQ: freq_r <= i_avs_writedata[WORD_W-1:0];
                    REG_MODE: mode_r <= i_avs_writedata[15:0];
                    default: ;
                endcase
            end
        end
    end

    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_avs_readdata <= 32'h0000_0000;
        end else if (i_avs_read && !ack_r) begin
            unique case (i_avs_address)
                REG_CTRL: o_avs_readdata <= {4'h0, mod_r, 12'h000, hop_r, ctrl_dither_r, ctrl_varb_r, start_r};
                REG_STATUS: o_avs_readdata <= {26'h0, ld_s2_r, mod_err_r, 1'b0, done_r, busy, 1'b0} | {28'h0, step_r};
                REG_FREQ: o_avs_readdata <= {8'h00, freq_r};
                REG_MODE: o_avs_readdata <= {16'h0000, mode_r};
                default: o_avs_readdata <= 32'h0000_0000;
            endcase
        end
    end

    // Lock detect pin synchroniser
    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            ld_s1_r <= 1'b0;
            ld_s2_r <= 1'b0;
        end else begin
            ld_s1_r <= i_lock_detect;
            ld_s2_r <= ld_s1_r;
        end
    end

    // ----------------------------------------------------------------
    // Sequencer
    // ----------------------------------------------------------------
    typedef enum logic [1:0] {SQ_IDLE, SQ_SEND, SQ_WAIT, SQ_PAUSE} fsi_sq_t;
    fsi_sq_t sq_r;
    logic [31:0] wait_r;
    logic go_r, sh_busy, sh_done, tick;
    logic [WORD_W-1:0] word;
    logic [4:0] len;

    // Step words in the fixed power-up order
    always_comb begin
        word = W_PD_ALL;
        len = WLEN8;
        unique case (step_r)
            ST_PD_ALL: begin word = W_PD_ALL; len = WLEN8; end
            ST_FUNC_GND: begin word = W_FUNC_GND; len = WLEN16; end
            ST_TEST: begin word = W_TEST_CLR; len = WLEN16; end
            ST_MODE0: begin word = W_MODE_INIT; len = WLEN16; end
            ST_MODE5: begin word = ctrl_varb_r ? W_MODE_B : W_MODE_A; len = WLEN16; end
            ST_TMR1: begin word = W_TMR_SW12; len = WLEN24; end
            ST_TMR2: begin word = W_TMR_SW3; len = WLEN24; end
            ST_TMR3: begin word = W_TMR_ICP; len = WLEN24; end
            ST_PHASE: begin word = W_PHASE; len = WLEN16; end
            ST_DIV: begin word = {W_DIVCFG[23:15], mod_r, W_DIVCFG[2:0]}; len = WLEN24; end
            ST_FREQ1: begin word = freq_r; len = WLEN24; end
            ST_FUNC_REL: begin word = W_FUNC_REL; len = WLEN16; end
            ST_PD_CLR: begin word = W_PD_CLR; len = WLEN8; end
            ST_FREQ2: begin word = freq_r; len = WLEN24; end
            ST_DITHER: begin
                word = {8'h00, DITHER_CODE, mode_r[MODE_DIT_LSB-1:0]};
                len = WLEN16;
            end
            ST_NONE: begin word = W_PD_ALL; len = WLEN8; end
        endcase
    end

    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            sq_r <= SQ_IDLE;
            step_r <= ST_NONE;
            go_r <= 1'b0;
            wait_r <= 32'h0;
            done_r <= 1'b0;
        end else begin
            go_r <= 1'b0;
            unique case (sq_r)
                SQ_IDLE: begin
                    if (start_r) begin
                        step_r <= ST_PD_ALL;
                        go_r <= 1'b1;
                        done_r <= 1'b0;
                        sq_r <= SQ_SEND;
                    end else if (hop_r && done_r) begin
                        step_r <= ST_FREQ2;
                        go_r <= 1'b1;
                        sq_r <= SQ_SEND;
                    end
                end
                SQ_SEND: begin
                    if (!go_r) begin
                        sq_r <= SQ_WAIT;
                    end
                end
                SQ_WAIT: begin
                    if (sh_done) begin
                        if (step_r == ST_FUNC_GND) begin
                            wait_r <= 32'(WAIT_CYCLES);
                            sq_r <= SQ_PAUSE;
                        end else if (step_r == ST_FREQ2 && done_r) begin
                            step_r <= ST_NONE;
                            sq_r <= SQ_IDLE;
                        end else if (step_r == ST_FREQ2 && ctrl_dither_r) begin
                            step_r <= ST_DITHER;
                            go_r <= 1'b1;
                            sq_r <= SQ_SEND;
                        end else if (step_r == ST_FREQ2 || step_r == ST_DITHER) begin
                            step_r <= ST_NONE;
                            done_r <= 1'b1;
                            sq_r <= SQ_IDLE;
                        end else begin
                            step_r <= fsi_step_t'(step_r + 4'h1);
                            go_r <= 1'b1;
                            sq_r <= SQ_SEND;
                        end
                    end
                end
                SQ_PAUSE: begin
                    if (wait_r <= 32'h1) begin
                        step_r <= ST_TEST;
                        go_r <= 1'b1;
                        sq_r <= SQ_SEND;
                    end else begin
                        wait_r <= wait_r - 32'h1;
                    end
                end
            endcase
        end
    end
    assign busy = (sq_r != SQ_IDLE) || sh_busy;

    // ----------------------------------------------------------------
    // Serial link
    // ----------------------------------------------------------------
    fsi_divider u_div (
        .i_mclk(i_mclk),
        .i_rst_n(i_rst_n),
        .i_run(sh_busy),
        .o_tick(tick)
    );

    fsi_shifter u_sh (
        .i_mclk(i_mclk),
        .i_rst_n(i_rst_n),
        .i_tick(tick),
        .i_go(go_r),
        .i_word(word),
        .i_len(len),
        .o_busy(sh_busy),
        .o_done(sh_done),
        .o_sclk(o_sclk),
        .o_sdata(o_sdata),
        .o_strobe(o_word_latch_strobe)
    );
endmodule
`default_nettype wire

// ==== rtl/fsi_pkg.sv ====
// Package: constants for the synthesizer init sequencer host controller
package fsi_pkg;
    // Avalon register map (byte addresses)
    localparam logic [3:0] REG_CTRL = 4'h0;
    localparam logic [3:0] REG_STATUS = 4'h4;
    localparam logic [3:0] REG_FREQ = 4'h8;
    localparam logic [3:0] REG_MODE = 4'hC;
    // Control fields
    localparam int CTRL_START_BIT = 0;
    localparam int CTRL_VARB_BIT = 1;
    localparam int CTRL_DITHER_BIT = 2;
    localparam int CTRL_HOP_BIT = 3;
    localparam int MOD_LSB = 16;
    localparam logic [11:0] MOD_MIN = 12'h00D;
    localparam logic [11:0] MOD_MIN_DITHER = 12'h032;
    localparam logic [11:0] MOD_RESET = 12'h041;
    // Word widths on the serial link
    localparam int WORD_W = 24;
    localparam logic [4:0] WLEN8 = 5'h08;
    localparam logic [4:0] WLEN16 = 5'h10;
    localparam logic [4:0] WLEN24 = 5'h18;
    // Sequence words
    localparam logic [23:0] W_PD_ALL = 24'h0000FD;
    localparam logic [23:0] W_FUNC_GND = 24'h00005B;
    localparam logic [23:0] W_TEST_CLR = 24'h000007;
    localparam logic [23:0] W_MODE_INIT = 24'h00000E;
    localparam logic [23:0] W_MODE_A = 24'h00900E;
    localparam logic [23:0] W_MODE_B = 24'h00000E;
    localparam logic [23:0] W_TMR_SW12 = 24'h004464;
    localparam logic [23:0] W_TMR_SW3 = 24'h00446C;
    localparam logic [23:0] W_TMR_ICP = 24'h004394;
    localparam logic [23:0] W_PHASE = 24'h0000D2;
    localparam logic [23:0] W_DIVCFG = 24'h520209;
    localparam logic [23:0] W_FREQ_DEF = 24'h480140;
    localparam logic [23:0] W_FUNC_REL = 24'h00007B;
    localparam logic [23:0] W_PD_CLR = 24'h000005;
    localparam logic [3:0] DITHER_CODE = 4'h3;
    localparam int MODE_DIT_LSB = 12;
    // Timing
    localparam real CLK_MHZ = 125.0;
    localparam real WAIT_MS = 10.0;
    localparam int WAIT_CYC = int'(WAIT_MS * 1000.0 * CLK_MHZ);
    localparam logic [7:0] SCLK_HALF = 8'h0A;
    // Steps
    typedef enum logic [3:0] {
        ST_PD_ALL, ST_FUNC_GND, ST_TEST, ST_MODE0, ST_MODE5, ST_TMR1, ST_TMR2, ST_TMR3,
        ST_PHASE, ST_DIV, ST_FREQ1, ST_FUNC_REL, ST_PD_CLR, ST_FREQ2, ST_DITHER, ST_NONE
    } fsi_step_t;
endpackage

// ==== rtl/fsi_shifter.sv ====
// Serial word shifter: MSB first, strobe pulse after last bit
`timescale 1ns/100ps
`default_nettype none
module fsi_shifter
    import fsi_pkg::*;
(
    input wire logic i_mclk,              // System clock
    input wire logic i_rst_n,             // Async reset
    input wire logic i_tick,              // Half-period enable
    input wire logic i_go,                // Start one word
    input wire logic [WORD_W-1:0] i_word, // Word, right aligned
    input wire logic [4:0] i_len,         // Bit count
    output logic o_busy,                  // Word in flight
    output logic o_done,                  // One-cycle completion
    output logic o_sclk,                  // Serial clock
    output logic o_sdata,                 // Serial data
    output logic o_strobe                 // Word latch strobe
);
    typedef enum logic [1:0] {SH_IDLE, SH_LOW, SH_HIGH, SH_STRB} fsi_sh_t;
    fsi_sh_t st_r;
    logic [WORD_W-1:0] sr_r;
    logic [4:0] left_r;
    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            st_r <= SH_IDLE;
            sr_r <= '0;
            left_r <= 5'h00;
            o_sclk <= 1'b0;
            o_sdata <= 1'b0;
            o_strobe <= 1'b0;
            o_done <= 1'b0;
        end else begin
            o_done <= 1'b0;
            unique case (st_r)
                SH_IDLE: begin
                    if (i_go) begin
                        // Left align so MSB leaves first
                        sr_r <= i_word << (5'(WORD_W) - i_len);
                        left_r <= i_len;
                        st_r <= SH_LOW;
                    end
                end
                SH_LOW: begin
                    if (i_tick) begin
                        o_sdata <= sr_r[WORD_W-1];
                        sr_r <= {sr_r[WORD_W-2:0], 1'b0};
                        left_r <= left_r - 5'h01;
                        o_sclk <= 1'b0;
                        st_r <= SH_HIGH;
                    end
                end
                SH_HIGH: begin
                    if (i_tick) begin
                        o_sclk <= 1'b1;
                        st_r <= (left_r == 5'h00) ? SH_STRB : SH_LOW;
                    end
                end
                SH_STRB: begin
                    if (i_tick) begin
                        // Strobe only after the whole word is in
                        o_sclk <= 1'b0;
                        o_strobe <= ~o_strobe;
                        if (o_strobe) begin
                            st_r <= SH_IDLE;
                            o_done <= 1'b1;
                        end
                    end
                end
            endcase
        end
    end
    assign o_busy = (st_r != SH_IDLE);
endmodule
`default_nettype wire
